// ### testbench/lfosc_osc_model.sv
`timescale 1ns/10ps
`default_nettype none

// Stands in for the analog core: still while disabled, slower as trim rises.
module lfosc_osc_model (
  input  wire logic                   osc_enable,
  input  wire lfosc_pkg::lfosc_trim_t osc_trim,
  output var  logic                   osc_raw
);
  import lfosc_pkg::*;

  // Edges sit 13 ns after a clock edge, so the synchroniser never races.
  initial
  begin
    osc_raw = 1'b0;
    forever
    begin
      if (osc_enable !== 1'b1)
      begin
        osc_raw = 1'b0;
        @(osc_enable);
        #13;
      end
      else
      begin
        #((6 + osc_trim) * 50);
        osc_raw = ~osc_raw;
      end
    end
  end
endmodule

`default_nettype wire

// ### testbench/test_low_freq_osc_control.sv
`timescale 1ns/10ps
`default_nettype none

// Self-checking bench for the low-frequency oscillator control block.
module test_low_freq_osc_control;
  import lfosc_pkg::*;

  logic        ref_clk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic        t2_mode = 1'b0, ext_sys = 1'b0, ext_per = 1'b0, mon_on = 1'b0;
  logic        t3_mode = 1'b1, m3_h = 1'b1;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [15:0] t2_cnt = 16'h0000, t3_cnt = 16'h0000, t2_rl, t3_rl, c_h0;
  logic [2:0]  xmode = 3'h0, lf_h;
  logic [1:0]  m_h;
  logic [31:0] seed = 32'h0001_2202, r;
  lfosc_trim_t trim_cal, osc_trim;
  logic        osc_raw, osc_enable, lf_clk_out, t2_cap, t3_cap;
  logic        p_one, p_two, sys_sel, per_sel;
  int          mismatches = 0, tests_run = 0;

  lfosc_ctrl #(.READY_CYCLES(2)) DUT (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(1'b1), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .trim_cal(trim_cal), .osc_raw(osc_raw), .osc_enable(osc_enable),
    .osc_trim(osc_trim), .lf_clk_out(lf_clk_out), .t2_capture_mode(t2_mode),
    .t3_capture_mode(t3_mode), .t2_count(t2_cnt), .t3_count(t3_cnt),
    .t2_capture(t2_cap), .t3_capture(t3_cap), .t2_reload(t2_rl), .t3_reload(t3_rl),
    .ext_osc_mode(xmode), .ext_sysclk_req(ext_sys), .ext_periph_req(ext_per),
    .p0_term_one_take(p_one), .p0_term_two_take(p_two), .ext_sysclk_sel(sys_sel),
    .ext_periph_sel(per_sel));

  lfosc_osc_model osc (.osc_enable(osc_enable), .osc_trim(osc_trim), .osc_raw(osc_raw));

  // Xorshift source of the random stimulus.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Divided-clock period in reference cycles for a divider code and trim.
  function automatic logic [15:0] exp_period(input logic [1:0] div, input logic [3:0] tr);
    return 16'((8 >> div) * 2 * (6 + tr));
  endfunction

  // Counts one comparison and reports a mismatch.
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A wait that ran out counts as a mismatch and ends the run.
  task automatic timeout();
    mismatches++;
    $display("Error at %0t: wait ran out", $time);
    complete_run();
  endtask

  // Register write: the strobe drops after the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask

  // Register read: data is looked at in the cycle after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    @(negedge ref_clk);
    d = sfr_rdata;
  endtask

  // Polls the control register until the ready flag shows.
  task automatic wait_ready();
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 200 && v[6] !== 1'b1; i++)
      rd(8'h86, v);
    if (v[6] !== 1'b1)
      timeout();
  endtask

  // Waits for the next timer three capture pulse.
  task automatic wait_cap();
    int i;
    @(negedge ref_clk);
    for (i = 0; i < 800 && t3_cap !== 1'b1; i++)
      @(negedge ref_clk);
    if (i == 800)
      timeout();
  endtask

  // Holds reset for three cycles and re-arms the capture checker after it.
  task automatic do_reset();
    mon_on = 1'b0;
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(negedge ref_clk);
    mon_on = 1'b1;
  endtask

  // Free-running 20 MHz reference clock.
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  // Timer models: timer three counts cycles, timer two shows random counts.
  always @(posedge ref_clk)
  begin
    r = rnd();
    t2_cnt <= r[15:0];
    t2_mode <= (r[17:16] != 2'h0);
    t3_cnt <= t3_cnt + 16'h0001;
  end

  // A divided-clock fall feeds timer two, a rise timer three, one cycle after the edge shows.
  always @(negedge ref_clk)
  begin
    if (mon_on)
    begin
      check(16'(t2_cap), 16'(m_h[0] & lf_h[1] & ~lf_h[0]), "t2 capture");
      check(16'(t3_cap), 16'(m3_h & ~lf_h[1] & lf_h[0]), "t3 capture");
      if (t2_cap === 1'b1)
        check(t2_rl, c_h0, "t2 reload");
    end
    lf_h = {lf_h[1:0], lf_clk_out};
    m_h = {m_h[0], t2_mode};
    m3_h = t3_mode;
    c_h0 = t2_cnt;
  end

  // Main sequence: reset, register access, divider codes, ready, pins.
  initial
  begin
    logic [7:0]  v, cur;
    logic [3:0]  tr;
    logic [15:0] p;
    logic [31:0] x;
    x = rnd();
    trim_cal = x[3:0];
    do_reset();
    rd(8'h86, v);
    check(16'(v), 16'({2'b00, trim_cal, 2'b00}), "reset value");
    wr(8'h87, 8'hff);
    rd(8'h87, v);
    check(16'(v), 16'h0000, "unmapped read");
    cur = {2'b00, trim_cal, 2'b00};
    wr(8'h86, cur | 8'h40);
    rd(8'h86, v);
    check(16'(v), 16'(cur), "ready write");
    for (int div = 0; div < 4; div++)
    begin
      x = rnd();
      tr = (div == 0) ? 4'h0 : (div == 3) ? 4'hf : x[3:0];
      wr(8'h86, cur & 8'h7f);
      cur = {2'b00, tr, 2'(div)};
      wr(8'h86, cur);
      wr(8'h86, cur | 8'h80);
      wait_ready();
      check(16'(osc_enable), 16'h0001, "enable");
      check(16'(osc_trim), 16'(tr), "trim out");
      wait_cap();
      p = t3_rl;
      wait_cap();
      check(t3_rl - p, exp_period(2'(div), tr), "period");
    end
    wr(8'h86, cur | 8'h80);
    rd(8'h86, v);
    check(16'(v), 16'(cur | 8'hc0), "same divider");
    wr(8'h86, cur);
    rd(8'h86, v);
    check(16'(v), 16'(cur | 8'h40), "disable");
    check(16'(osc_enable), 16'h0000, "osc off");
    wr(8'h86, cur ^ 8'h81);
    rd(8'h86, v);
    check(16'(v), 16'(cur ^ 8'h81), "divider change");
    for (int m = 0; m < 32; m++)
    begin
      @(posedge ref_clk);
      {xmode, ext_sys, ext_per} <= 5'(m);
      t3_mode <= 1'b0;
      repeat (2) @(negedge ref_clk);
      check(16'(p_one), 16'(xmode[2:1] == 2'h3), "P0.2 claim");
      check(16'(p_two), 16'(xmode[2:1] != 2'h0), "P0.3 claim");
      check(16'(sys_sel), 16'(ext_sys && xmode[2:1] != 2'h0), "sysclk");
      check(16'(per_sel), 16'(ext_per && xmode[2:1] != 2'h0), "periph");
    end
    // Timer three stays out of capture mode while the divided clock keeps rising.
    repeat (200) @(posedge ref_clk);
    @(posedge ref_clk);
    trim_cal <= ~trim_cal;
    do_reset();
    rd(8'h86, v);
    check(16'(v), 16'({2'b00, trim_cal, 2'b00}), "second reset");
    complete_run();
  end
endmodule

`default_nettype wire

// ### verilog/lfosc_ctrl.sv
// How it works
// - Divider codes 00,01,10,11 divide 8,4,2,1.
// - Oscillator runs only while enable bit set.
// - Ready flag rises once frequency stabilised.
// - Ready clears only on reset or divider change.
// - Trim code 0000 fastest, 1111 slowest.
// - Timer two captures falls, three captures rises.
// - Capture copies sixteen-bit count into reload.
// - Crystal mode claims port bits two, three.
// - Capacitor, RC, clock modes claim bit three.
// - External oscillator may feed system or timers.
`timescale 1ns/10ps
`default_nettype none
`include "lfosc_defines.svh"

module lfosc_ctrl #(
  parameter int READY_CYCLES = `LFO_READY_CYCLES
) (
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic               clk_en,
  input  wire logic [7:0]         sfr_addr,
  input  wire logic               sfr_wr,
  input  wire logic               sfr_rd,
  input  wire logic [7:0]         sfr_wdata,
  output var  logic [7:0]         sfr_rdata,
  input  wire lfosc_pkg::lfosc_trim_t trim_cal,
  input  wire logic               osc_raw,
  output var  logic               osc_enable,
  output var  lfosc_pkg::lfosc_trim_t osc_trim,
  output var  logic               lf_clk_out,
  input  wire logic               t2_capture_mode,
  input  wire logic               t3_capture_mode,
  input  wire logic [15:0]        t2_count,
  input  wire logic [15:0]        t3_count,
  output var  logic               t2_capture,
  output var  logic               t3_capture,
  output var  logic [15:0]        t2_reload,
  output var  logic [15:0]        t3_reload,
  input  wire logic [2:0]         ext_osc_mode,
  input  wire logic               ext_sysclk_req,
  input  wire logic               ext_periph_req,
  output var  logic               p0_term_one_take,
  output var  logic               p0_term_two_take,
  output var  logic               ext_sysclk_sel,
  output var  logic               ext_periph_sel
);
  import lfosc_pkg::*;

  localparam int CW = $clog2(READY_CYCLES + 1);

  logic               lf_osc_enable_q;   // Enable bit of the control register.
  logic               lf_osc_ready_q;    // Read-only ready flag.
  lfosc_trim_t        lf_freq_trim_q;    // Frequency trim field.
  lfosc_div_t         lf_divider_select_q; // Divider select field.
  logic               cal_loaded_q;      // High once the calibration trim is loaded.
  logic               osc_s1_q;          // First synchroniser stage.
  logic               osc_s2_q;          // Second synchroniser stage.
  logic               osc_s3_q;          // Third synchroniser stage.
  logic               osc_lvl_q;         // Accepted oscillator level.
  logic               osc_rise;          // Accepted rising edge of the oscillator.
  logic               lf_prev_q;         // Divided clock one cycle earlier.
  lfosc_state_e       state_q;           // Stabilisation state.
  logic [CW-1:0]      settle_cnt_q;      // Oscillator cycles seen while settling.
  logic               wr_hit;            // Write to the control register.
  logic               div_change;        // Write that changes the divider field.
  logic               lf_rise;           // Rising edge of the divided clock.
  logic               lf_fall;           // Falling edge of the divided clock.
  logic               osc_gated;         // Oscillator level while enabled.

  // Maps an external oscillator mode to the port pins it occupies.
  function automatic lfosc_pins_e pins_of(input logic [2:0] mode);
    lfosc_pins_e p;
    p = LFOSC_PINS_ONE;
    if ((mode & `LFO_XMODE_OFF_MSK) == `LFO_XMODE_OFF)
      p = LFOSC_PINS_NONE;
    else if ((mode & `LFO_XMODE_XTAL_MSK) == `LFO_XMODE_XTAL)
      p = LFOSC_PINS_TWO;
    return p;
  endfunction

  assign wr_hit     = sfr_wr && (sfr_addr == `LFO_CTRL_ADDR);
  assign div_change = wr_hit &&
                      (sfr_wdata[`LFO_DIV_MSB:`LFO_DIV_LSB] != lf_divider_select_q);
  assign osc_rise   = lf_osc_enable_q && !osc_lvl_q && (osc_s2_q == osc_s3_q) && osc_s3_q;
  assign osc_gated  = osc_lvl_q && lf_osc_enable_q;
  assign lf_rise    = !lf_prev_q && lf_clk_out;
  assign lf_fall    = lf_prev_q && !lf_clk_out;

  // Three-flop synchroniser; the level changes only when stages two and three agree.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_s1_q  <= 1'b0;
      osc_s2_q  <= 1'b0;
      osc_s3_q  <= 1'b0;
      osc_lvl_q <= 1'b0;
    end
    else if (clk_en)
    begin
      osc_s1_q <= osc_raw;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      if (osc_s2_q == osc_s3_q)
        osc_lvl_q <= osc_s3_q;
    end
  end

  // Writable control fields; trim takes the calibration constant after reset release.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lf_osc_enable_q     <= `LFO_EN_RST;
      lf_divider_select_q <= `LFO_DIV_RST;
      lf_freq_trim_q      <= `LFO_TRIM_RST;
      cal_loaded_q        <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!cal_loaded_q)
      begin
        // The strap-like calibration input is caught once, after release.
        lf_freq_trim_q <= trim_cal;
        cal_loaded_q   <= 1'b1;
      end
      else if (wr_hit)
        lf_freq_trim_q <= sfr_wdata[`LFO_TRIM_MSB:`LFO_TRIM_LSB];
      if (wr_hit)
      begin
        lf_osc_enable_q     <= sfr_wdata[`LFO_EN_BIT];
        lf_divider_select_q <= sfr_wdata[`LFO_DIV_MSB:`LFO_DIV_LSB];
      end
    end
  end

  // Settling machine: counts oscillator cycles after enable or a divider change.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q        <= LFOSC_IDLE;
      settle_cnt_q   <= '0;
      lf_osc_ready_q <= `LFO_RDY_RST;
    end
    else if (clk_en)
    begin
      if (div_change)
        lf_osc_ready_q <= 1'b0;
      case (state_q)
        LFOSC_IDLE:
        begin
          settle_cnt_q <= '0;
          if (lf_osc_enable_q)
            state_q <= LFOSC_SETTLE;
        end
        LFOSC_SETTLE:
        begin
          if (!lf_osc_enable_q)
            state_q <= LFOSC_IDLE;
          else if (div_change)
            settle_cnt_q <= '0;
          else if (osc_rise)
          begin
            if (settle_cnt_q == CW'(READY_CYCLES - 1))
            begin
              // Stabilised: raise the flag.
              state_q        <= LFOSC_STABLE;
              lf_osc_ready_q <= 1'b1;
            end
            else
              settle_cnt_q <= settle_cnt_q + CW'(1);
          end
        end
        LFOSC_STABLE:
        begin
          // Disabling leaves the flag alone; only a divider change restarts settling.
          settle_cnt_q <= '0;
          if (div_change)
            state_q <= lf_osc_enable_q ? LFOSC_SETTLE : LFOSC_IDLE;
        end
        default:
          state_q <= LFOSC_IDLE;
      endcase
    end
  end

  // Divided low-frequency clock.
  lfosc_divider u_div (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .osc_lvl  (osc_gated),
    .osc_rise (osc_rise),
    .div_sel  (lf_divider_select_q),
    .clear    (div_change),
    .div_out  (lf_clk_out)
  );

  // Timer captures on the edges of the divided clock.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lf_prev_q  <= 1'b0;
      t2_capture <= 1'b0;
      t3_capture <= 1'b0;
      t2_reload  <= 16'h0000;
      t3_reload  <= 16'h0000;
    end
    else if (clk_en)
    begin
      lf_prev_q  <= lf_clk_out;
      t2_capture <= t2_capture_mode && lf_fall;
      t3_capture <= t3_capture_mode && lf_rise;
      if (t2_capture_mode && lf_fall)
        t2_reload <= t2_count;
      if (t3_capture_mode && lf_rise)
        t3_reload <= t3_count;
    end
  end

  // Register read port and analog core controls.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sfr_rdata  <= 8'h00;
      osc_enable <= 1'b0;
      osc_trim   <= `LFO_TRIM_RST;
    end
    else if (clk_en)
    begin
      osc_enable <= lf_osc_enable_q;
      osc_trim   <= lf_freq_trim_q;
      if (sfr_rd && (sfr_addr == `LFO_CTRL_ADDR))
        sfr_rdata <= {lf_osc_enable_q, lf_osc_ready_q, lf_freq_trim_q, lf_divider_select_q};
      else
        sfr_rdata <= 8'h00;
    end
  end

  // External oscillator pin ownership and clock routing.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      p0_term_one_take <= 1'b0;
      p0_term_two_take <= 1'b0;
      ext_sysclk_sel   <= 1'b0;
      ext_periph_sel   <= 1'b0;
    end
    else if (clk_en)
    begin
      p0_term_one_take <= (pins_of(ext_osc_mode) == LFOSC_PINS_TWO);
      p0_term_two_take <= (pins_of(ext_osc_mode) != LFOSC_PINS_NONE);
      ext_sysclk_sel   <= ext_sysclk_req && (pins_of(ext_osc_mode) != LFOSC_PINS_NONE);
      ext_periph_sel   <= ext_periph_req && (pins_of(ext_osc_mode) != LFOSC_PINS_NONE);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_div_write;
    clk_en && div_change;
  endsequence

  sequence s_t2_edge;
    clk_en && t2_capture_mode && lf_fall;
  endsequence

  chk_ready_div_clear: assert property (s_div_write |=> !lf_osc_ready_q)
    else $error("ready flag survived a divider change");
  chk_ready_held: assert property (lf_osc_ready_q && !div_change |=> lf_osc_ready_q)
    else $error("ready flag dropped without a divider change");
  chk_ready_after_count: assert property ($rose(lf_osc_ready_q) |->
      $past(state_q) == LFOSC_SETTLE && $past(settle_cnt_q) == CW'(READY_CYCLES - 1))
    else $error("ready flag rose before the settling count");
  chk_enable_pin: assert property (clk_en && wr_hit ##1 clk_en |=>
      osc_enable == $past(sfr_wdata[`LFO_EN_BIT], 2))
    else $error("oscillator enable does not follow the written bit");
  chk_core_held_off: assert property (clk_en && !lf_osc_enable_q |=> !osc_enable)
    else $error("analog core left running while disabled");
  chk_div_one_pass: assert property (clk_en && lf_divider_select_q == `LFO_DIV_BY1 |=>
      lf_clk_out == $past(osc_gated))
    else $error("divide-by-one output does not follow the oscillator");
  chk_t2_fall_cap: assert property (s_t2_edge |=> t2_capture && t2_reload == $past(t2_count))
    else $error("timer two capture missed");
  chk_t3_rise_cap: assert property (clk_en && t3_capture_mode && lf_rise |=>
      t3_capture && t3_reload == $past(t3_count))
    else $error("timer three capture missed");
  chk_trim_drive: assert property (clk_en ##1 clk_en |=> osc_trim == $past(lf_freq_trim_q))
    else $error("trim output lags the trim field");
  chk_xtal_pins: assert property (clk_en && pins_of(ext_osc_mode) == LFOSC_PINS_TWO |=>
      p0_term_one_take && p0_term_two_take)
    else $error("crystal mode did not claim both terminals");
  chk_one_pin: assert property (clk_en && pins_of(ext_osc_mode) == LFOSC_PINS_ONE |=>
      !p0_term_one_take && p0_term_two_take)
    else $error("single-pin mode claimed the wrong terminals");

endmodule
`default_nettype wire

// ### verilog/lfosc_defines.svh
`ifndef LFOSC_DEFINES_SVH
`define LFOSC_DEFINES_SVH

// Control register address on the special-function-register bus.
`define LFO_CTRL_ADDR      8'h86
// Field positions inside the control register.
`define LFO_EN_BIT         7
`define LFO_RDY_BIT        6
`define LFO_TRIM_MSB       5
`define LFO_TRIM_LSB       2
`define LFO_DIV_MSB        1
`define LFO_DIV_LSB        0
// Reset values of the plain fields.
`define LFO_EN_RST         1'h0
`define LFO_RDY_RST        1'h0
`define LFO_DIV_RST        2'h0
`define LFO_TRIM_RST       4'h0
// Divider select codes.
`define LFO_DIV_BY8        2'h0
`define LFO_DIV_BY4        2'h1
`define LFO_DIV_BY2        2'h2
`define LFO_DIV_BY1        2'h3
// Oscillator cycles counted before the ready flag rises.
`define LFO_READY_CYCLES   16
// External oscillator mode codes and masks.
`define LFO_XMODE_OFF_MSK  3'h6
`define LFO_XMODE_OFF      3'h0
`define LFO_XMODE_XTAL_MSK 3'h6
`define LFO_XMODE_XTAL     3'h6
// Port bit positions taken by the external oscillator.
`define LFO_P0_TERM_ONE    2
`define LFO_P0_TERM_TWO    3

`endif

// ### verilog/lfosc_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "lfosc_defines.svh"

// Divides the synchronised oscillator by 1, 2, 4 or 8.
module lfosc_divider (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic                  clk_en,
  input  wire logic                  osc_lvl,
  input  wire logic                  osc_rise,
  input  wire lfosc_pkg::lfosc_div_t div_sel,
  input  wire logic                  clear,
  output var  logic                  div_out
);
  import lfosc_pkg::*;

  // Counts oscillator rising edges; each bit is a binary division.
  logic [2:0] rise_cnt_q;

  // Selects the output level for a divider code.
  function automatic logic pick(input lfosc_div_t sel, input logic lvl,
                                input logic [2:0] cnt);
    logic res;
    res = lvl;
    case (sel)
      `LFO_DIV_BY8: res = cnt[2];
      `LFO_DIV_BY4: res = cnt[1];
      `LFO_DIV_BY2: res = cnt[0];
      default:      res = lvl;
    endcase
    return res;
  endfunction

  // The edge counter restarts when the divider changes so the new ratio starts clean.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rise_cnt_q <= 3'h0;
    else if (clk_en)
    begin
      if (clear)
        rise_cnt_q <= 3'h0;
      else if (osc_rise)
        rise_cnt_q <= rise_cnt_q + 3'h1;
    end
  end

  // Output level is held in a flop; code 11 passes the oscillator undivided.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      div_out <= 1'b0;
    else if (clk_en)
      div_out <= pick(div_sel, osc_lvl, rise_cnt_q);
  end

endmodule
`default_nettype wire

// ### verilog/lfosc_pkg.sv
package lfosc_pkg;

  // Stabilisation progress of the low-frequency oscillator.
  typedef enum logic [1:0] {
    LFOSC_IDLE,
    LFOSC_SETTLE,
    LFOSC_STABLE
  } lfosc_state_e;

  // How many port pins the external oscillator claims.
  typedef enum logic [1:0] {
    LFOSC_PINS_NONE,
    LFOSC_PINS_ONE,
    LFOSC_PINS_TWO
  } lfosc_pins_e;

  typedef logic [1:0] lfosc_div_t;
  typedef logic [3:0] lfosc_trim_t;

endpackage
